/* File: inc/scp_pkg.sv */
// Purpose: constants and types for the clock select and prescale block
// Assumes: 125 MHz core_clk; registers at word offsets of a plain port
// Notes:   fuse codes, timing counts and register layouts live here
package scp_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_TRIM      = 4'h0;
   localparam logic [3:0] ADDR_DIVCTL    = 4'h1;
   localparam logic [3:0] ADDR_TIMER_OSC = 4'h2;
   localparam logic [3:0] ADDR_STATUS    = 4'h3;

   localparam int UNLOCK_BIT  = 7;
   localparam int EXT_IN_BIT  = 0;
   localparam int RANGE_BIT   = 7;

   localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
   localparam logic [3:0] DIV_RESET_EIGHT = 4'h3;
   localparam logic [3:0] DIV_MAX_CODE    = 4'h8;
   localparam logic [7:0] TRIM_DEFAULT    = 8'h80;

   // ----------------------------------------------------------------
   // fuse codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SRC_EXT_CLOCK = 4'h0;
   localparam logic [3:0] SRC_INT_RC    = 4'h2;
   localparam logic [3:0] SRC_LF_FAST   = 4'h6;
   localparam logic [3:0] SRC_LF_SLOW   = 4'h7;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ         = 125;
   localparam int UNLOCK_CYCLES   = 4;
   localparam int EXT_WAKE_CK     = 6;
   localparam int LF_FAST_WAKE_CK = 1024;
   localparam int LF_SLOW_WAKE_CK = 32768;
   localparam int RESET_BASE_CK   = 14;
   localparam int DELAY_SHORT_US  = 4100;
   localparam int DELAY_LONG_US   = 65000;
   localparam int DELAY_SHORT_CK  = DELAY_SHORT_US * CLK_MHZ;
   localparam int DELAY_LONG_CK   = DELAY_LONG_US * CLK_MHZ;

   typedef enum logic [1:0]
   {
      SCP_RUN   = 2'b00,
      SCP_RSTW  = 2'b01,
      SCP_WAKEW = 2'b10,
      SCP_HOLD  = 2'b11
   } scp_phase_t;

   typedef struct packed
   {
      logic [3:0] src;
      logic [1:0] startup_delay_fuses;
      logic       clk_out;
      logic       div8;
   } scp_fuse_t;

   typedef struct packed
   {
      scp_phase_t phase;
      logic [23:0] wait_cnt;
      logic [7:0]  trim;
      logic [3:0]  div_sel;
      logic [3:0]  div_act;
      logic [2:0]  unlock_cnt;
      logic        ext_in;
      logic [7:0]  div_cnt;
      logic        clk_en;
      logic [7:0]  rdata;
      logic        fuse_taken;
      logic [1:0]  pin_sync;
      logic [1:0]  wake_sync;
   } scp_state_t;

endpackage : scp_pkg

/* File: logic/scp_clock_ctrl.sv */
// Purpose: clock source select, start-up delays and glitch-free prescaler
// Assumes: core_clk is the undivided source; divided clock given as enable
// Notes:   fuses are static straps, captured once after reset release
//
// How it works
// - low-frequency crystal wakes after 1K/32K cycles
// - source code 0000 uses crystal input pin
// - external clock: 6-cycle wake, 14CK plus delay
// - timer oscillator only with internal RC source
// - ext input bit takes clock on timer pin
// - clock out fuse drives clock pin always
// - clock pin carries the divided clock, crystal pin at code 0000
// - prescaler divides all system clocks, any source
// - divide switch glitch-free, never faster
// - new rate within old plus two new
// - unlock only by lone bit-7 write
// - unlock clears after four cycles or use
// - reset divider 0000, or 0011 with fuse
// - any divider value accepted through unlock
// - code n divides by two to n, codes above 8 by 256
// - trim loads factory value on first edge after reset release
// - trim bit 7 selects frequency range
// - trim low bits tune monotonically
// - source code 0010 selects internal RC
// - crystal delay code 00 adds 14 cycles
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
module scp_clock_ctrl
#(
   parameter int                 LONG_DELAY_CK  = scp_pkg::DELAY_LONG_CK,
   parameter int                 SHORT_DELAY_CK = scp_pkg::DELAY_SHORT_CK,
   parameter int                 LF_SLOW_CK     = scp_pkg::LF_SLOW_WAKE_CK,
   parameter logic [7:0]         FACTORY_TRIM   = scp_pkg::TRIM_DEFAULT
)
(
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire scp_pkg::scp_fuse_t fuses,
   input  wire logic             crystal_input_pin,
   input  wire logic             timer_osc_pin_one,
   input  wire logic             wake_req,
   input  wire logic [3:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [7:0]            reg_rdata,
   output logic                  sys_clk_en,
   output logic                  core_ready,
   output logic                  clock_out_pin,
   output logic                  clock_out_oe,
   output logic                  use_ext_clock,
   output logic                  timer_osc_enable,
   output logic                  timer_osc_clk_sel,
   output logic [7:0]            oscillator_trim
);

   scp_pkg::scp_state_t s_r;
   scp_pkg::scp_state_t s_nxt;

   logic                 wr_trim;
   logic                 wr_div;
   logic                 lone_unlock;
   logic                 is_rc;
   logic                 div_hit;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] div_mask(input logic [3:0] code);
      logic [7:0] m;
      m = 8'h00;
      if (code <= scp_pkg::DIV_MAX_CODE && code != 4'h0)
         m = 8'hFF >> (4'd8 - code);
      else if (code > scp_pkg::DIV_MAX_CODE)
         m = 8'hFF;
      return m;
   endfunction : div_mask

   function automatic logic [23:0] reset_wait(input logic [1:0] startup_delay_fuses,
                                              input logic [3:0] src);
      logic [23:0] w;
      w = 24'(scp_pkg::RESET_BASE_CK);
      if (src == scp_pkg::SRC_LF_FAST || src == scp_pkg::SRC_LF_SLOW)
      begin
         if (startup_delay_fuses == 2'b01)
            w = 24'(scp_pkg::RESET_BASE_CK + SHORT_DELAY_CK);
         else if (startup_delay_fuses == 2'b10)
            w = 24'(scp_pkg::RESET_BASE_CK + LONG_DELAY_CK);
      end
      else
      begin
         case (startup_delay_fuses)
            2'b01:   w = 24'(scp_pkg::RESET_BASE_CK + SHORT_DELAY_CK);
            2'b10:   w = 24'(scp_pkg::RESET_BASE_CK + LONG_DELAY_CK);
            default: w = 24'(scp_pkg::RESET_BASE_CK);
         endcase
      end
      return w;
   endfunction : reset_wait

   function automatic logic [23:0] wake_wait(input logic [3:0] src);
      logic [23:0] w;
      case (src)
         scp_pkg::SRC_LF_FAST: w = 24'(scp_pkg::LF_FAST_WAKE_CK);
         scp_pkg::SRC_LF_SLOW: w = 24'(LF_SLOW_CK);
         default:              w = 24'(scp_pkg::EXT_WAKE_CK);
      endcase
      return w;
   endfunction : wake_wait

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign wr_trim     = reg_wr && reg_addr == scp_pkg::ADDR_TRIM;
   assign wr_div      = reg_wr && reg_addr == scp_pkg::ADDR_DIVCTL;
   assign lone_unlock = wr_div && reg_wdata == 8'h80;
   assign is_rc       = s_r.fuse_taken && fuses.src == scp_pkg::SRC_INT_RC;
   // prescaler counter reaching the selected count gives one enable
   assign div_hit     = (s_r.div_cnt & div_mask(s_r.div_act)) ==
                        div_mask(s_r.div_act);

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.pin_sync  = {s_r.pin_sync[0], timer_osc_pin_one};
      s_nxt.wake_sync = {s_r.wake_sync[0], wake_req};
      s_nxt.rdata     = 8'h00;

      // straps are captured once, first edge after reset release
      if (!s_r.fuse_taken)
      begin
         s_nxt.fuse_taken = 1'b1;
         s_nxt.div_sel    = fuses.div8 ? scp_pkg::DIV_RESET_EIGHT
                                       : scp_pkg::DIV_RESET_PLAIN;
         s_nxt.div_act    = s_nxt.div_sel;
         s_nxt.trim       = FACTORY_TRIM;
         s_nxt.wait_cnt   = reset_wait(fuses.startup_delay_fuses, fuses.src);
         s_nxt.phase      = (fuses.startup_delay_fuses == 2'b11) ? scp_pkg::SCP_HOLD
                                                 : scp_pkg::SCP_RSTW;
      end
      else
      begin
         case (s_r.phase)
            scp_pkg::SCP_RSTW, scp_pkg::SCP_WAKEW:
            begin
               if (s_r.wait_cnt <= 24'h000001)
                  s_nxt.phase = scp_pkg::SCP_RUN;
               s_nxt.wait_cnt = s_r.wait_cnt - 24'h000001;
            end
            scp_pkg::SCP_RUN:
            begin
               if (s_r.wake_sync[1])
               begin
                  s_nxt.phase    = scp_pkg::SCP_WAKEW;
                  s_nxt.wait_cnt = wake_wait(fuses.src);
               end
            end
            scp_pkg::SCP_HOLD:
               s_nxt.phase = scp_pkg::SCP_HOLD;
            default:
               s_nxt.phase = scp_pkg::SCP_HOLD;
         endcase
      end

      // unlock window: fixed length, rewrite neither extends nor clears
      if (s_r.unlock_cnt != 3'h0)
         s_nxt.unlock_cnt = s_r.unlock_cnt - 3'h1;
      if (lone_unlock && s_r.unlock_cnt == 3'h0)
         s_nxt.unlock_cnt = 3'(scp_pkg::UNLOCK_CYCLES);
      else if (wr_div && !reg_wdata[scp_pkg::UNLOCK_BIT] && s_r.unlock_cnt != 3'h0)
      begin
         s_nxt.div_sel    = reg_wdata[3:0];
         s_nxt.unlock_cnt = 3'h0;
      end

      if (wr_trim)
         s_nxt.trim = reg_wdata;
      if (reg_wr && reg_addr == scp_pkg::ADDR_TIMER_OSC)
         s_nxt.ext_in = reg_wdata[scp_pkg::EXT_IN_BIT];

      // prescaler: new setting only adopted on an output edge
      s_nxt.clk_en  = 1'b0;
      s_nxt.div_cnt = s_r.div_cnt + 8'h01;
      if (div_hit)
      begin
         s_nxt.clk_en  = 1'b1;
         s_nxt.div_cnt = 8'h00;
         s_nxt.div_act = s_r.div_sel;
      end

      if (reg_rd)
      begin
         case (reg_addr)
            scp_pkg::ADDR_TRIM:
               s_nxt.rdata = s_r.trim;
            scp_pkg::ADDR_DIVCTL:
               s_nxt.rdata = {(s_r.unlock_cnt != 3'h0), 3'b000, s_r.div_sel};
            scp_pkg::ADDR_TIMER_OSC:
               s_nxt.rdata = {7'h00, s_r.ext_in};
            scp_pkg::ADDR_STATUS:
               s_nxt.rdata = {2'b00, s_r.div_act, s_r.phase};
            default:
               s_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         s_r <= '{phase: scp_pkg::SCP_HOLD, wait_cnt: 24'h000000,
                  trim: scp_pkg::TRIM_DEFAULT, div_sel: scp_pkg::DIV_RESET_PLAIN,
                  div_act: scp_pkg::DIV_RESET_PLAIN, unlock_cnt: 3'h0,
                  ext_in: 1'b0, div_cnt: 8'h00, clk_en: 1'b0, rdata: 8'h00,
                  fuse_taken: 1'b0, pin_sync: 2'b00, wake_sync: 2'b00};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata         = s_r.rdata;
   assign sys_clk_en        = s_r.clk_en;
   assign core_ready        = s_r.phase == scp_pkg::SCP_RUN && s_r.fuse_taken;
   assign use_ext_clock     = fuses.src == scp_pkg::SRC_EXT_CLOCK;
   // timer oscillator shares crystal pins, so only legal on internal RC
   assign timer_osc_enable  = is_rc;
   assign timer_osc_clk_sel = is_rc && s_r.ext_in && s_r.pin_sync[1];
   assign oscillator_trim   = s_r.trim;
   // clock out runs even in reset, carries crystal pin at code 0, else the divided rate
   assign clock_out_oe      = fuses.clk_out;
   assign clock_out_pin     = fuses.clk_out &&
                              (s_r.div_act == 4'h0 ? crystal_input_pin : s_r.clk_en);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_unlock_four: assert property (@(posedge core_clk) disable iff (reset)
      (lone_unlock && s_r.unlock_cnt == 3'h0 && s_r.fuse_taken)
         |=> (s_r.unlock_cnt == 3'd4) ##4 (s_r.unlock_cnt == 3'h0))
      else $error("unlock window not four cycles");
   chk_unlock_lone: assert property (@(posedge core_clk) disable iff (reset)
      (wr_div && reg_wdata != 8'h80 && s_r.unlock_cnt == 3'h0) |=> s_r.unlock_cnt == 3'h0)
      else $error("unlock set by mixed write");
   chk_div_locked: assert property (@(posedge core_clk) disable iff (reset)
      (s_r.fuse_taken && s_r.unlock_cnt == 3'h0 && !lone_unlock) |=> $stable(s_r.div_sel))
      else $error("divider changed while locked");
   chk_div_taken: assert property (@(posedge core_clk) disable iff (reset)
      (wr_div && !reg_wdata[7] && s_r.unlock_cnt != 3'h0)
         |=> s_r.div_sel == $past(reg_wdata[3:0]))
      else $error("divider write lost");
   chk_rd_zero: assert property (@(posedge core_clk) disable iff (reset)
      (reg_rd && reg_addr == scp_pkg::ADDR_DIVCTL) |=> reg_rdata[6:4] == 3'b000)
      else $error("unused prescale bits not zero");
   chk_div_two: assert property (@(posedge core_clk) disable iff (reset)
      (s_r.clk_en && s_r.div_act == 4'h1) |=> !s_r.clk_en ##1 s_r.clk_en)
      else $error("divide by two wrong");
   chk_no_back: assert property (@(posedge core_clk) disable iff (reset)
      (s_r.clk_en && s_r.div_act != 4'h0 && $stable(s_r.div_act)) |=> !s_r.clk_en)
      else $error("glitch in divided clock");
   chk_reset_div: assert property (@(posedge core_clk) disable iff (reset)
      (!s_r.fuse_taken) |=> s_r.div_sel == (fuses.div8 ? 4'h3 : 4'h0))
      else $error("divider reset value wrong");
   chk_clk_out: assert property (@(posedge core_clk) disable iff (reset)
      fuses.clk_out |-> clock_out_oe)
      else $error("clock out not driven");
   chk_rc_only: assert property (@(posedge core_clk) disable iff (reset)
      timer_osc_enable |-> fuses.src == scp_pkg::SRC_INT_RC)
      else $error("timer osc without internal rc");
   chk_rc_timer: assert property (@(posedge core_clk) disable iff (reset)
      (s_r.fuse_taken && fuses.src == scp_pkg::SRC_INT_RC) |-> timer_osc_enable)
      else $error("internal rc without timer osc");
   chk_clk_out_div: assert property (@(posedge core_clk) disable iff (reset)
      (fuses.clk_out && s_r.div_act != 4'h0) |-> clock_out_pin == s_r.clk_en)
      else $error("clock pin not divided clock");
   chk_clk_out_off: assert property (@(posedge core_clk) disable iff (reset)
      !fuses.clk_out |-> !clock_out_pin)
      else $error("clock pin active without fuse");

   // ----------------------------------------------------------------
   // start-up and wake timing
   // ----------------------------------------------------------------
   // a held-high wake request only retriggers once run is reached again
   chk_reset_wait: assert property (@(posedge core_clk) disable iff (reset)
      (!s_r.fuse_taken && fuses.startup_delay_fuses == 2'b00)
         |=> !core_ready [*8] ##6 !core_ready ##1 core_ready)
      else $error("reset delay not fourteen cycles");
   chk_reset_hold: assert property (@(posedge core_clk) disable iff (reset)
      (s_r.fuse_taken && fuses.startup_delay_fuses == 2'b11) |-> !core_ready)
      else $error("reserved delay code left hold");
   chk_wake_start: assert property (@(posedge core_clk) disable iff (reset)
      (core_ready && s_r.wake_sync[1]) |=> !core_ready)
      else $error("wake wait not entered");
   chk_wake_ext: assert property (@(posedge core_clk) disable iff (reset)
      (core_ready && s_r.wake_sync[1] && fuses.src == scp_pkg::SRC_EXT_CLOCK)
         |=> !core_ready [*6] ##1 core_ready)
      else $error("external wake not six cycles");
   chk_wake_lf: assert property (@(posedge core_clk) disable iff (reset)
      (core_ready && s_r.wake_sync[1] && fuses.src == scp_pkg::SRC_LF_FAST)
         |=> !core_ready ##300 !core_ready)
      else $error("crystal wake too short");
   chk_fuse_once: assert property (@(posedge core_clk) disable iff (reset)
      s_r.fuse_taken |=> s_r.fuse_taken)
      else $error("straps captured twice");

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   chk_cnt_range: assert property (@(posedge core_clk) disable iff (reset)
      s_r.div_cnt <= div_mask(s_r.div_act))
      else $error("prescale count past its end");
   chk_hit_pulse: assert property (@(posedge core_clk) disable iff (reset)
      1'b1 |=> sys_clk_en == $past(div_hit))
      else $error("enable pulse not from count end");
   chk_adopt_edge: assert property (@(posedge core_clk) disable iff (reset)
      !div_hit |=> $stable(s_r.div_act))
      else $error("divider adopted between edges");
   chk_div_one: assert property (@(posedge core_clk) disable iff (reset)
      (s_r.fuse_taken && s_r.div_act == 4'h0 && $stable(s_r.div_act)) |-> s_r.clk_en)
      else $error("divide by one lost a pulse");
   chk_div_gap: assert property (@(posedge core_clk) disable iff (reset)
      (s_r.clk_en && s_r.div_act == 4'h2 && $stable(s_r.div_act))
         |=> !s_r.clk_en [*3] ##1 s_r.clk_en)
      else $error("divide by four wrong");

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   chk_unlock_max: assert property (@(posedge core_clk) disable iff (reset)
      s_r.unlock_cnt <= 3'd4)
      else $error("unlock window too long");
   chk_unlock_clear: assert property (@(posedge core_clk) disable iff (reset)
      (wr_div && !reg_wdata[7] && s_r.unlock_cnt != 3'h0) |=> s_r.unlock_cnt == 3'h0)
      else $error("unlock kept after divider write");
   chk_unlock_renew: assert property (@(posedge core_clk) disable iff (reset)
      (lone_unlock && s_r.unlock_cnt != 3'h0)
         |=> s_r.unlock_cnt == $past(s_r.unlock_cnt) - 3'h1)
      else $error("unlock rewrite changed window");
   chk_trim_write: assert property (@(posedge core_clk) disable iff (reset)
      wr_trim |=> oscillator_trim == $past(reg_wdata))
      else $error("trim write lost");
   chk_trim_hold: assert property (@(posedge core_clk) disable iff (reset)
      (s_r.fuse_taken && !wr_trim) |=> $stable(oscillator_trim))
      else $error("trim changed without write");
   chk_trim_factory: assert property (@(posedge core_clk) disable iff (reset)
      !s_r.fuse_taken |=> oscillator_trim == FACTORY_TRIM)
      else $error("factory trim not loaded");
   chk_ext_write: assert property (@(posedge core_clk) disable iff (reset)
      (reg_wr && reg_addr == scp_pkg::ADDR_TIMER_OSC) |=> s_r.ext_in == $past(reg_wdata[0]))
      else $error("timer input bit write lost");
   chk_ext_follow: assert property (@(posedge core_clk) disable iff (reset)
      (is_rc && s_r.ext_in) |-> timer_osc_clk_sel == s_r.pin_sync[1])
      else $error("timer pin not selected");
   chk_rdata_idle: assert property (@(posedge core_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data without read");
   chk_rd_trim: assert property (@(posedge core_clk) disable iff (reset)
      (reg_rd && reg_addr == scp_pkg::ADDR_TRIM) |=> reg_rdata == $past(s_r.trim))
      else $error("trim read wrong");
   chk_rd_unlock: assert property (@(posedge core_clk) disable iff (reset)
      (reg_rd && reg_addr == scp_pkg::ADDR_DIVCTL)
         |=> reg_rdata[7] == ($past(s_r.unlock_cnt) != 3'h0))
      else $error("unlock bit read wrong");

endmodule : scp_clock_ctrl

/* File: testbench/scp_ext_clock_model.sv */
// Purpose: far-side sources for the clock block: crystal pin and timer pin
// Assumes: crystal pin carries a steady external clock from time zero
// Notes:   timer pin sits low unless tosc_run is high
module scp_ext_clock_model
#(
   parameter int XTAL_HALF_NS = 40,
   parameter int TOSC_HALF_NS = 400
)
(
   input  wire logic tosc_run,
   output logic      crystal_input_pin,
   output logic      timer_osc_pin_one
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // sources
   // ----------------------------------------------------------------
   // fixed 12.5 MHz, never drifts, so reset need not cover a change
   initial
   begin
      crystal_input_pin = 1'b0;
      forever #XTAL_HALF_NS crystal_input_pin = ~crystal_input_pin;
   end

   // slow timer clock, far below a quarter of the system clock
   initial
   begin
      timer_osc_pin_one = 1'b0;
      forever
      begin
         #TOSC_HALF_NS;
         timer_osc_pin_one = tosc_run ? ~timer_osc_pin_one : 1'b0;
      end
   end
endmodule : scp_ext_clock_model

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the clock select and prescale block
// Assumes: short delay parameters; register port as in the package
// Notes:   read results are queued by the driver and checked by a monitor
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic               core_clk, reset, wake_req, reg_wr, reg_rd, tosc_run, rd_seen;
   logic               crystal_input_pin, timer_osc_pin_one, sys_clk_en, core_ready;
   logic               clock_out_pin, clock_out_oe, use_ext_clock;
   logic               timer_osc_enable, timer_osc_clk_sel;
   scp_pkg::scp_fuse_t fuses;
   logic [3:0]         reg_addr;
   logic [7:0]         reg_wdata, reg_rdata, oscillator_trim, rv;
   logic [31:0]        exp_q[$];
   int                 fail_count, checks, cyc, i, c;

   scp_clock_ctrl #(.LONG_DELAY_CK(20), .SHORT_DELAY_CK(10), .LF_SLOW_CK(40),
      .FACTORY_TRIM(8'h5A)) u_scp_clock_ctrl (.core_clk(core_clk), .reset(reset),
      .fuses(fuses), .crystal_input_pin(crystal_input_pin),
      .timer_osc_pin_one(timer_osc_pin_one), .wake_req(wake_req), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sys_clk_en(sys_clk_en), .core_ready(core_ready), .clock_out_pin(clock_out_pin),
      .clock_out_oe(clock_out_oe), .use_ext_clock(use_ext_clock),
      .timer_osc_enable(timer_osc_enable), .timer_osc_clk_sel(timer_osc_clk_sel),
      .oscillator_trim(oscillator_trim));

   scp_ext_clock_model u_scp_ext_clock_model (.tosc_run(tosc_run),
      .crystal_input_pin(crystal_input_pin), .timer_osc_pin_one(timer_osc_pin_one));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("counts: checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      exp_q.push_back({24'h0, e});
   endtask : rd

   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
      end
   endtask : idle

   task automatic gap(output int n);
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (sys_clk_en !== 1'b1 && n < 600);
   endtask : gap

   task automatic do_reset(input scp_pkg::scp_fuse_t f);
      fuses <= f;
      reset <= 1'b1;
      repeat (5) @(posedge core_clk);
      chk("clock out enable in reset", {31'h0, f.clk_out}, {31'h0, clock_out_oe});
      reset <= 1'b0;
   endtask : do_reset

   // ----------------------------------------------------------------
   // clock, monitor, timeout
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      if (rd_seen)
         chk("read data", exp_q.pop_front(), {24'h0, reg_rdata});
      rd_seen <= reg_rd;
      cyc++;
      if (cyc > 20000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      {reset, wake_req, reg_wr, reg_rd, tosc_run, rd_seen, reg_addr, reg_wdata} = '1;
      {wake_req, reg_wr, reg_rd, tosc_run, rd_seen, reg_addr, reg_wdata} = '0;
      fuses = '0;
      rv = 8'($urandom(32'hDF82));
      do_reset('{src: scp_pkg::SRC_EXT_CLOCK, startup_delay_fuses: 2'b00, clk_out: 1'b1, div8: 1'b1});
      idle(1);
      chk("external clock select", 32'h1, {31'h0, use_ext_clock});
      chk("timer osc off", 32'h0, {31'h0, timer_osc_enable});
      idle(7);
      chk("ready early", 32'h0, {31'h0, core_ready});
      idle(12);
      chk("ready after delay", 32'h1, {31'h0, core_ready});
      rd(scp_pkg::ADDR_TRIM, 8'h5A);
      rd(scp_pkg::ADDR_DIVCTL, 8'h03);
      rd(4'hF, 8'h00);
      idle(2);
      $display("test reset values done");
      wr(scp_pkg::ADDR_DIVCTL, 8'h81);
      wr(scp_pkg::ADDR_DIVCTL, 8'h05);
      rd(scp_pkg::ADDR_DIVCTL, 8'h03);
      wr(scp_pkg::ADDR_DIVCTL, 8'h80);
      wr(scp_pkg::ADDR_DIVCTL, 8'h80);
      rd(scp_pkg::ADDR_DIVCTL, 8'h83);
      wr(scp_pkg::ADDR_DIVCTL, 8'h75);
      rd(scp_pkg::ADDR_DIVCTL, 8'h05);
      wr(scp_pkg::ADDR_DIVCTL, 8'h80);
      idle(2);
      wr(scp_pkg::ADDR_DIVCTL, 8'h80);
      idle(2);
      wr(scp_pkg::ADDR_DIVCTL, 8'h02);
      rd(scp_pkg::ADDR_DIVCTL, 8'h05);
      idle(2);
      $display("test unlock sequence done");
      for (i = 0; i < 10; i++)
      begin
         wr(scp_pkg::ADDR_DIVCTL, 8'h80);
         wr(scp_pkg::ADDR_DIVCTL, 8'(i));
         rd(scp_pkg::ADDR_DIVCTL, 8'(i));
         idle(1);
         gap(c);
         gap(c);
         gap(c);
         chk("divide period", (i > 8) ? 256 : (1 << i), 32'(c));
         chk("clock out pin", {31'h0, (i == 0) ? crystal_input_pin : sys_clk_en},
             {31'h0, clock_out_pin});
      end
      rd(scp_pkg::ADDR_STATUS, 8'h24);
      $display("test divide codes done");
      repeat (4)
      begin
         rv = 8'($urandom);
         wr(scp_pkg::ADDR_TRIM, rv);
         rd(scp_pkg::ADDR_TRIM, rv);
         idle(1);
         chk("trim output", {24'h0, rv}, {24'h0, oscillator_trim});
      end
      $display("test trim done");
      wake_req <= 1'b1;
      idle(1);
      wake_req <= 1'b0;
      idle(3);
      chk("ready in wake wait", 32'h0, {31'h0, core_ready});
      idle(12);
      chk("ready after wake", 32'h1, {31'h0, core_ready});
      $display("test wake done");
      do_reset('{src: scp_pkg::SRC_INT_RC, startup_delay_fuses: 2'b01, clk_out: 1'b0, div8: 1'b0});
      idle(18);
      chk("ready before short delay", 32'h0, {31'h0, core_ready});
      chk("timer osc on", 32'h1, {31'h0, timer_osc_enable});
      idle(16);
      chk("ready after short delay", 32'h1, {31'h0, core_ready});
      rd(scp_pkg::ADDR_DIVCTL, 8'h00);
      wr(scp_pkg::ADDR_TIMER_OSC, 8'h01);
      idle(1);
      tosc_run <= 1'b1;
      c = 0;
      while (timer_osc_pin_one !== 1'b1 && c < 200)
      begin
         @(posedge core_clk);
         c++;
      end
      idle(4);
      chk("timer clock select", 32'h1, {31'h0, timer_osc_clk_sel});
      $display("test internal source done");
      give_verdict();
   end
endmodule : tb
